/* test_port.sv */
// Boundary test port controller and test pin control
`timescale 1ns/10ps
module test_port (
   // Clock and reset
   input  wire logic i_clk_sys,
   input  wire logic i_rst,
   // Test access port pins
   input  wire logic i_test_port_clock,
   input  wire logic i_test_port_mode_select,
   input  wire logic i_test_port_serial_in,
   input  wire logic i_test_port_reset_n,
   output logic      o_test_port_serial_out,
   output logic      o_test_port_serial_out_oe_n,
   // Housekeeping pins
   input  wire logic i_output_float_n,
   input  wire logic i_scan_test_n,
   input  wire logic i_master_reset_n,
   output logic      o_scan_test_mode,
   output logic      o_core_reset,
   output logic      o_float_all,
   // General pin eight
   input  wire logic i_general_pin_eight_mode_pmu,
   input  wire logic i_general_pin_eight_out,
   input  wire logic i_general_pin_eight_dir_out,
   input  wire logic i_general_pin_eight_in,
   output logic      o_general_pin_eight_out,
   output logic      o_general_pin_eight_oe_n,
   output logic      o_general_pin_eight_level,
   output logic      o_perf_monitor_update,
   output logic      o_perf_monitor_phase_err,
   // Controller observation
   output logic [3:0] o_instruction
);

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers and glitch filter
   ////////////////////////////////////////////////////////////////////////
   logic [5:0] raw_in;              // Asynchronous pin levels
   logic [5:0] s1_reg;              // First stage, read only by s2
   logic [5:0] s2_reg;              // Second stage
   logic [5:0] s3_reg;              // Third stage
   logic [5:0] filt_reg;            // Accepted levels
   logic [5:0] filt_next;
   logic       tck_rise;            // Test clock rising edge seen
   logic       tck_fall;            // Test clock falling edge seen
   logic       pin8_rise;           // Accepted rise on pin eight
   logic       core_rst;            // Local reset of clocked logic

   assign raw_in = {i_general_pin_eight_in, i_output_float_n,
                    i_test_port_reset_n, i_test_port_serial_in,
                    i_test_port_mode_select, i_test_port_clock};

   // Level accepted only when second and third stages agree
   always_comb begin
      filt_next = (~(s2_reg ^ s3_reg) & s3_reg) |
                  ((s2_reg ^ s3_reg) & filt_reg);
   end

   // Shift the synchroniser chain
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         s1_reg   <= test_port_pkg::SYN_RESET;
         s2_reg   <= test_port_pkg::SYN_RESET;
         s3_reg   <= test_port_pkg::SYN_RESET;
         filt_reg <= test_port_pkg::SYN_RESET;
      end else begin
         s1_reg   <= raw_in;
         s2_reg   <= s1_reg;
         s3_reg   <= s2_reg;
         filt_reg <= filt_next;
      end
   end

   assign tck_rise  = filt_next[test_port_pkg::B_TCK] &
                      ~filt_reg[test_port_pkg::B_TCK];
   assign tck_fall  = ~filt_next[test_port_pkg::B_TCK] &
                      filt_reg[test_port_pkg::B_TCK];
   assign pin8_rise = filt_next[test_port_pkg::B_PIN8] &
                      ~filt_reg[test_port_pkg::B_PIN8];

   ////////////////////////////////////////////////////////////////////////
   // Asynchronous scan and reset pins, float from synchronised levels
   ////////////////////////////////////////////////////////////////////////
   // Scan mode direct
   assign o_scan_test_mode = ~i_scan_test_n;
   assign o_core_reset     = ~i_master_reset_n;
   // Local logic also held while master reset is low
   assign core_rst         = i_rst | ~i_master_reset_n;
   assign o_float_all = ~filt_reg[test_port_pkg::B_FLOAT_N] &
                        ~filt_reg[test_port_pkg::B_TRST_N];

   ////////////////////////////////////////////////////////////////////////
   // Controller state machine
   ////////////////////////////////////////////////////////////////////////
   test_port_pkg::tap_state_t state_reg;
   test_port_pkg::tap_state_t state_next;
   logic tms;                       // Accepted mode select
   logic tdi;                       // Accepted serial input
   logic trst_n;                    // Accepted test reset

   assign tms    = filt_reg[test_port_pkg::B_TMS];
   assign tdi    = filt_reg[test_port_pkg::B_TDI];
   assign trst_n = filt_reg[test_port_pkg::B_TRST_N];

   // Next state on each test clock rise
   always_comb begin
      state_next = state_reg;
      if (!trst_n) begin
         state_next = test_port_pkg::ST_RESET;
      end else if (tck_rise) begin
         case (state_reg)
            test_port_pkg::ST_RESET: state_next = tms ?
               test_port_pkg::ST_RESET : test_port_pkg::ST_IDLE;
            test_port_pkg::ST_IDLE: state_next = tms ?
               test_port_pkg::ST_SEL_DR : test_port_pkg::ST_IDLE;
            test_port_pkg::ST_SEL_DR: state_next = tms ?
               test_port_pkg::ST_SEL_IR : test_port_pkg::ST_CAP_DR;
            test_port_pkg::ST_CAP_DR: state_next = tms ?
               test_port_pkg::ST_EXIT1_DR : test_port_pkg::ST_SHIFT_DR;
            test_port_pkg::ST_SHIFT_DR: state_next = tms ?
               test_port_pkg::ST_EXIT1_DR : test_port_pkg::ST_SHIFT_DR;
            test_port_pkg::ST_EXIT1_DR: state_next = tms ?
               test_port_pkg::ST_UPD_DR : test_port_pkg::ST_PAUSE_DR;
            test_port_pkg::ST_PAUSE_DR: state_next = tms ?
               test_port_pkg::ST_EXIT2_DR : test_port_pkg::ST_PAUSE_DR;
            test_port_pkg::ST_EXIT2_DR: state_next = tms ?
               test_port_pkg::ST_UPD_DR : test_port_pkg::ST_SHIFT_DR;
            test_port_pkg::ST_UPD_DR: state_next = tms ?
               test_port_pkg::ST_SEL_DR : test_port_pkg::ST_IDLE;
            test_port_pkg::ST_SEL_IR: state_next = tms ?
               test_port_pkg::ST_RESET : test_port_pkg::ST_CAP_IR;
            test_port_pkg::ST_CAP_IR: state_next = tms ?
               test_port_pkg::ST_EXIT1_IR : test_port_pkg::ST_SHIFT_IR;
            test_port_pkg::ST_SHIFT_IR: state_next = tms ?
               test_port_pkg::ST_EXIT1_IR : test_port_pkg::ST_SHIFT_IR;
            test_port_pkg::ST_EXIT1_IR: state_next = tms ?
               test_port_pkg::ST_UPD_IR : test_port_pkg::ST_PAUSE_IR;
            test_port_pkg::ST_PAUSE_IR: state_next = tms ?
               test_port_pkg::ST_EXIT2_IR : test_port_pkg::ST_PAUSE_IR;
            test_port_pkg::ST_EXIT2_IR: state_next = tms ?
               test_port_pkg::ST_UPD_IR : test_port_pkg::ST_SHIFT_IR;
            test_port_pkg::ST_UPD_IR: state_next = tms ?
               test_port_pkg::ST_SEL_DR : test_port_pkg::ST_IDLE;
            default: state_next = test_port_pkg::ST_RESET;
         endcase
      end
   end

   // Register the controller state
   always_ff @(posedge i_clk_sys) begin
      if (core_rst) begin
         state_reg <= test_port_pkg::ST_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Instruction and data shift paths, serial output
   ////////////////////////////////////////////////////////////////////////
   logic [3:0]  ir_shift_reg;       // Instruction shift stage
   logic [3:0]  ir_shift_next;
   logic [3:0]  ir_reg;             // Active instruction
   logic [3:0]  ir_next;
   logic [31:0] dr_shift_reg;       // Selected data shift stage
   logic [31:0] dr_shift_next;
   logic        tdo_reg;            // Serial output level
   logic        tdo_next;
   logic        tdo_oe_n_reg;       // Serial output enable, low drives
   logic        tdo_oe_n_next;
   logic        shifting;           // A register is selected to shift

   assign shifting = (state_reg == test_port_pkg::ST_SHIFT_DR) ||
                     (state_reg == test_port_pkg::ST_SHIFT_IR);

   // Capture, shift and update on test clock edges
   always_comb begin
      ir_shift_next = ir_shift_reg;
      ir_next       = ir_reg;
      dr_shift_next = dr_shift_reg;
      tdo_next      = tdo_reg;
      tdo_oe_n_next = tdo_oe_n_reg;
      if (!trst_n) begin
         ir_next       = test_port_pkg::IR_RESET;
         tdo_oe_n_next = 1'b1;
      end else if (tck_rise) begin
         case (state_reg)
            test_port_pkg::ST_RESET:
               ir_next = test_port_pkg::IR_RESET;
            test_port_pkg::ST_CAP_IR:
               ir_shift_next = test_port_pkg::IR_CAPTURE;
            test_port_pkg::ST_SHIFT_IR:
               ir_shift_next = {tdi, ir_shift_reg[3:1]};
            test_port_pkg::ST_UPD_IR:
               ir_next = ir_shift_reg;
            test_port_pkg::ST_CAP_DR:
               dr_shift_next = (ir_reg == test_port_pkg::OP_IDCODE) ?
                               test_port_pkg::ID_VALUE : 32'h0000_0000;
            test_port_pkg::ST_SHIFT_DR: begin
               // Identification uses all bits, others one bypass bit
               if (ir_reg == test_port_pkg::OP_IDCODE) begin
                  dr_shift_next = {tdi, dr_shift_reg[31:1]};
               end else begin
                  dr_shift_next = {31'h0, tdi};
               end
            end
            default: dr_shift_next = dr_shift_reg;
         endcase
      end else if (tck_fall) begin
         tdo_next = (state_reg == test_port_pkg::ST_SHIFT_IR) ?
                    ir_shift_reg[0] : dr_shift_reg[0];
         tdo_oe_n_next = ~shifting;
      end
   end

   // Register shift paths and serial output
   always_ff @(posedge i_clk_sys) begin
      if (core_rst) begin
         ir_shift_reg <= test_port_pkg::IR_RESET;
         ir_reg       <= test_port_pkg::IR_RESET;
         dr_shift_reg <= 32'h0000_0000;
         tdo_reg      <= 1'b0;
         tdo_oe_n_reg <= 1'b1;
      end else begin
         ir_shift_reg <= ir_shift_next;
         ir_reg       <= ir_next;
         dr_shift_reg <= dr_shift_next;
         tdo_reg      <= tdo_next;
         tdo_oe_n_reg <= tdo_oe_n_next;
      end
   end

   assign o_test_port_serial_out      = tdo_reg;
   assign o_test_port_serial_out_oe_n = tdo_oe_n_reg | o_float_all;
   assign o_instruction               = ir_reg;

   ////////////////////////////////////////////////////////////////////////
   // General pin eight and update input
   ////////////////////////////////////////////////////////////////////////
   logic [5:0] phase_cnt_reg;       // Cycles since last accepted change
   logic [5:0] phase_cnt_next;
   logic       pmu_upd_reg;         // Update pulse
   logic       pmu_upd_next;
   logic       pmu_err_reg;         // Sticky short-phase flag
   logic       pmu_err_next;
   logic       pin8_chg;            // Accepted change on pin eight

   assign pin8_chg = filt_next[test_port_pkg::B_PIN8] ^
                     filt_reg[test_port_pkg::B_PIN8];

   // Measure phases and issue update pulses
   always_comb begin
      phase_cnt_next = phase_cnt_reg;
      pmu_upd_next   = 1'b0;
      pmu_err_next   = pmu_err_reg;
      if (i_general_pin_eight_mode_pmu) begin
         if (pin8_chg) begin
            phase_cnt_next = 6'h00;
            if (phase_cnt_reg < 6'(test_port_pkg::PMU_MIN_CYC)) begin
               pmu_err_next = 1'b1;
            end
            pmu_upd_next = pin8_rise;
         end else if (phase_cnt_reg != 6'h3F) begin
            phase_cnt_next = phase_cnt_reg + 6'h01;
         end
      end else begin
         phase_cnt_next = 6'h3F;
         pmu_err_next   = 1'b0;
      end
   end

   // Register phase measurement
   always_ff @(posedge i_clk_sys) begin
      if (core_rst) begin
         phase_cnt_reg <= 6'h3F;
         pmu_upd_reg   <= 1'b0;
         pmu_err_reg   <= 1'b0;
      end else begin
         phase_cnt_reg <= phase_cnt_next;
         pmu_upd_reg   <= pmu_upd_next;
         pmu_err_reg   <= pmu_err_next;
      end
   end

   assign o_general_pin_eight_out   = i_general_pin_eight_out;
   assign o_general_pin_eight_oe_n  = ~i_general_pin_eight_dir_out |
                                      i_general_pin_eight_mode_pmu |
                                      o_float_all;
   assign o_general_pin_eight_level = filt_reg[test_port_pkg::B_PIN8];
   assign o_perf_monitor_update     = pmu_upd_reg;
   assign o_perf_monitor_phase_err  = pmu_err_reg;

endmodule : test_port

/* test_port_bench.sv */
// Self-checking bench for the test port block
`timescale 1ns/10ps
module test_port_bench;
   logic       i_clk_sys = 1'b0;  // System clock
   logic       i_rst = 1'b1;      // Synchronous reset
   logic       tck, tms, tdi, trst_n, tdo, tdo_oe_n;
   logic       float_n = 1'b1, scan_n = 1'b1, mrst_n = 1'b1;
   logic       p8_pmu = 1'b0, p8_out = 1'b0, p8_dir = 1'b0, p8_in = 1'b0;
   logic       scan_mode, core_rst, float_all, p8_o, p8_oe_n, p8_lvl;
   logic       upd, perr;
   logic [3:0] instr;
   int         fails = 0, n_checks = 0, cyc = 0, n_upd = 0;

   test_port u_dut (
      .i_clk_sys(i_clk_sys), .i_rst(i_rst),
      .i_test_port_clock(tck), .i_test_port_mode_select(tms),
      .i_test_port_serial_in(tdi), .i_test_port_reset_n(trst_n),
      .o_test_port_serial_out(tdo), .o_test_port_serial_out_oe_n(tdo_oe_n),
      .i_output_float_n(float_n), .i_scan_test_n(scan_n),
      .i_master_reset_n(mrst_n), .o_scan_test_mode(scan_mode),
      .o_core_reset(core_rst), .o_float_all(float_all),
      .i_general_pin_eight_mode_pmu(p8_pmu),
      .i_general_pin_eight_out(p8_out),
      .i_general_pin_eight_dir_out(p8_dir),
      .i_general_pin_eight_in(p8_in), .o_general_pin_eight_out(p8_o),
      .o_general_pin_eight_oe_n(p8_oe_n), .o_general_pin_eight_level(p8_lvl),
      .o_perf_monitor_update(upd), .o_perf_monitor_phase_err(perr),
      .o_instruction(instr));
   test_port_tester u_tester (.o_tck(tck), .o_tms(tms), .o_tdi(tdi),
      .o_trst_n(trst_n), .i_tdo(tdo), .i_tdo_oe_n(tdo_oe_n));

   ////////////////////////////////////////////////////////////////////////
   always #10 i_clk_sys = ~i_clk_sys;
   // Update pulse count and hang ceiling
   always @(posedge i_clk_sys) begin
      cyc <= cyc + 1;
      if (upd === 1'b1) n_upd <= n_upd + 1;
      if (cyc == 30000) begin
         fails++;
         complete_run();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         $display("ERROR %0t got %h want %h", $time, got, exp);
         fails++;
      end
   endtask : check
   task automatic wait_cyc(input int n);
      repeat (n) @(negedge i_clk_sys);
   endtask : wait_cyc
   // Walk the controller, first mode bit in bit 0
   task automatic walk(input logic [3:0] seq, input int n);
      logic b;
      for (int k = 0; k < n; k++) u_tester.step(seq[k], 1'b1, b);
   endtask : walk
   // Shift n bits LSB first, then update and go idle
   task automatic shift(input int n, input logic [31:0] di,
                        output logic [31:0] dq);
      logic b;
      dq = '0;
      for (int k = 0; k < n; k++) begin
         u_tester.step(k == n - 1, di[k], b);
         dq[k] = b;
      end
      walk(4'h1, 2);
   endtask : shift

   ////////////////////////////////////////////////////////////////////////
   task automatic t_idcode();
      logic [31:0] q;
      walk(4'h2, 4);
      shift(32, 32'h0, q);
      check(q, test_port_pkg::ID_VALUE);
      wait_cyc(8);
      check(tdo_oe_n, 1'b1);
   endtask : t_idcode
   task automatic t_bypass();
      logic [31:0] q;
      walk(4'h3, 4);
      shift(4, 32'hF, q);
      check(q, 32'(test_port_pkg::IR_CAPTURE));
      check(instr, test_port_pkg::OP_BYPASS);
      walk(4'h1, 3);
      shift(8, 32'hA5, q);
      check(q, 32'h4A);
   endtask : t_bypass
   // Bypass bit held across a pause, output floating while paused
   task automatic t_pause();
      logic [4:0] q;
      walk(4'h1, 3);
      for (int k = 0; k < 5; k++) begin
         u_tester.step(k[0] == 1'b0, k == 0, q[k]);
         if (k == 2) check(tdo_oe_n, 1'b1);
      end
      walk(4'h1, 2);
      check({q[4], q[0]}, 2'h2);
   endtask : t_pause
   task automatic t_float();
      p8_dir = 1'b1;
      float_n = 1'b0;
      wait_cyc(8);
      check({float_all, p8_oe_n}, 2'b00);
      u_tester.set_reset(1'b0);
      wait_cyc(8);
      check({tdo_oe_n, instr, float_all, p8_oe_n}, 7'h47);
      float_n = 1'b1;
      u_tester.set_reset(1'b1);
      wait_cyc(8);
   endtask : t_float
   task automatic t_async();
      logic [31:0] q;
      // Load bypass so the master reset has an instruction to clear
      walk(4'h0, 1);
      walk(4'h3, 4);
      shift(4, 32'hF, q);
      check(instr, test_port_pkg::OP_BYPASS);
      scan_n = 1'b0;
      mrst_n = 1'b0;
      #1;
      check({scan_mode, core_rst}, 2'b11);
      wait_cyc(3);
      scan_n = 1'b1;
      mrst_n = 1'b1;
      #1;
      check({scan_mode, core_rst}, 2'b00);
      wait_cyc(8);
      check(instr, test_port_pkg::IR_RESET);
   endtask : t_async
   task automatic t_pin8();
      int base;
      p8_out = 1'b1;
      wait_cyc(1);
      check({p8_oe_n, p8_o}, 2'b01);
      p8_pmu = 1'b1;
      base = n_upd;
      repeat (2) begin
         p8_in = 1'b1;
         wait_cyc(30);
         check(p8_lvl, 1'b1);
         p8_in = 1'b0;
         wait_cyc(30);
      end
      check({4'(n_upd - base), p8_oe_n, perr, p8_lvl}, 7'h14);
      p8_in = 1'b1;
      wait_cyc(10);
      p8_in = 1'b0;
      wait_cyc(30);
      check(perr, 1'b1);
      p8_pmu = 1'b0;
      wait_cyc(5);
      check(perr, 1'b0);
   endtask : t_pin8

   task automatic complete_run();
      if (fails == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : complete_run

   // Main sequence
   initial begin
      wait_cyc(10);
      i_rst = 1'b0;
      u_tester.set_reset(1'b1);
      wait_cyc(6);
      check({tdo_oe_n, instr, upd, perr}, 7'h44);
      t_idcode();
      t_bypass();
      t_pause();
      t_float();
      t_async();
      t_pin8();
      complete_run();
   end
endmodule : test_port_bench

/* test_port_monitor.sv */
// Concurrent checks on the test port block pins
`timescale 1ns/10ps
module test_port_monitor (
   // Clock and reset
   input wire logic       i_clk_sys,
   input wire logic       i_rst,
   // Test port pins
   input wire logic       i_test_port_clock,
   input wire logic       i_test_port_reset_n,
   input wire logic       o_test_port_serial_out,
   input wire logic       o_test_port_serial_out_oe_n,
   input wire logic [3:0] o_instruction,
   // Housekeeping and pin eight
   input wire logic       i_output_float_n,
   input wire logic       i_scan_test_n,
   input wire logic       i_master_reset_n,
   input wire logic       o_scan_test_mode,
   input wire logic       o_core_reset,
   input wire logic       o_float_all,
   input wire logic       i_general_pin_eight_mode_pmu,
   input wire logic       o_perf_monitor_update
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   ////////////////////////////////////////////////////////////////////////
   logic       tck_q;    // Raw test clock, last cycle
   logic [3:0] fell_ago; // Cycles since raw test clock fall
   logic [3:0] quiet;    // Cycles with both resets released

   // Edge age and reset quiet counters
   always_ff @(posedge i_clk_sys) begin
      tck_q <= i_test_port_clock;
      if (i_rst || (tck_q && !i_test_port_clock)) fell_ago <= 4'h0;
      else if (fell_ago != 4'hF) fell_ago <= fell_ago + 4'h1;
      if (i_rst || !i_test_port_reset_n || !i_master_reset_n) quiet <= 4'h0;
      else if (quiet != 4'hF) quiet <= quiet + 4'h1;
   end

   ////////////////////////////////////////////////////////////////////////
   property p_scan; o_scan_test_mode == !i_scan_test_n; endproperty
   a_scan: assert property (p_scan) else $error("scan mode wrong");
   property p_core; o_core_reset == !i_master_reset_n; endproperty
   a_core: assert property (p_core) else $error("core reset wrong");
   property p_rst;
      $fell(i_rst) |-> o_test_port_serial_out_oe_n && o_instruction == 4'h1;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
   property p_trst;
      !i_test_port_reset_n [*6] |->
         o_test_port_serial_out_oe_n && o_instruction == 4'h1;
   endproperty
   a_trst: assert property (p_trst) else $error("test reset ignored");
   property p_float_on;
      (!i_output_float_n && !i_test_port_reset_n) [*6] |-> o_float_all;
   endproperty
   a_float_on: assert property (p_float_on) else $error("no float");
   property p_float_off; i_output_float_n [*6] |-> !o_float_all; endproperty
   a_float_off: assert property (p_float_off)
      else $error("bad float");
   property p_pulse;
      o_perf_monitor_update |->
         $past(i_general_pin_eight_mode_pmu) ##1 !o_perf_monitor_update;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("update pulse wrong");
   property p_tdo_fall;
      quiet == 4'hF && ($changed(o_test_port_serial_out) ||
         $changed(o_test_port_serial_out_oe_n)) |->
         fell_ago inside {[4'h2:4'h6]};
   endproperty
   a_tdo_fall: assert property (p_tdo_fall)
      else $error("tdo off fall");
endmodule : test_port_monitor

bind test_port test_port_monitor u_mon (.*);

/* test_port_pkg.sv */
// Constants for the boundary test port and test pin logic
package test_port_pkg;
   // Controller states, one-hot
   typedef enum logic [15:0] {
      ST_RESET      = 16'h0001,
      ST_IDLE       = 16'h0002,
      ST_SEL_DR     = 16'h0004,
      ST_CAP_DR     = 16'h0008,
      ST_SHIFT_DR   = 16'h0010,
      ST_EXIT1_DR   = 16'h0020,
      ST_PAUSE_DR   = 16'h0040,
      ST_EXIT2_DR   = 16'h0080,
      ST_UPD_DR     = 16'h0100,
      ST_SEL_IR     = 16'h0200,
      ST_CAP_IR     = 16'h0400,
      ST_SHIFT_IR   = 16'h0800,
      ST_EXIT1_IR   = 16'h1000,
      ST_PAUSE_IR   = 16'h2000,
      ST_EXIT2_IR   = 16'h4000,
      ST_UPD_IR     = 16'h8000
   } tap_state_t;

   // Instruction register
   localparam int         IR_W        = 4;
   localparam logic [3:0] IR_CAPTURE  = 4'h1;
   localparam logic [3:0] OP_IDCODE   = 4'h1;
   localparam logic [3:0] OP_BYPASS   = 4'hF;
   localparam logic [3:0] IR_RESET    = 4'h1;

   // Data register width and identification value (value is arbitrary)
   localparam int          DR_W       = 32;
   localparam logic [31:0] ID_VALUE   = 32'h1234_5671;

   // Synchronised input bit positions
   localparam int SYN_W       = 6;
   localparam int B_TCK       = 0;
   localparam int B_TMS       = 1;
   localparam int B_TDI       = 2;
   localparam int B_TRST_N    = 3;
   localparam int B_FLOAT_N   = 4;
   localparam int B_PIN8      = 5;
   localparam logic [5:0] SYN_RESET = 6'h1E;

   // Update-input phase limit
   localparam int CLK_PERIOD_NS = 20;
   localparam int PMU_MIN_NS    = 500;
   localparam int PMU_MIN_CYC   =
      (PMU_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PHASE_W       = 6;
endpackage : test_port_pkg

/* test_port_tester.sv */
// Boundary-scan tester model driving the test port pins
`timescale 1ns/10ps
module test_port_tester (
   // Pins toward the device
   output logic      o_tck,
   output logic      o_tms,
   output logic      o_tdi,
   output logic      o_trst_n,
   input  wire logic i_tdo,
   input  wire logic i_tdo_oe_n
);
   // Clock stands low between frames, pulled-up lines idle high
   initial begin
      o_tck = 1'b0;
      o_tms = 1'b1;
      o_tdi = 1'b1;
      o_trst_n = 1'b0;
   end

   // Drive the test reset pin
   task automatic set_reset(input logic v);
      o_trst_n = v;
   endtask : set_reset

   // Pins timed only from this test clock
   // One 160 ns test clock period; returns output seen before the fall
   task automatic step(input logic ms, input logic di, output logic so);
      // Mode and data set up a half period before the rise
      o_tms = ms;
      o_tdi = di;
      #80;
      o_tck = 1'b1;
      #80;
      // Read late in the high phase; floating reads unknown
      so = i_tdo_oe_n ? 1'bx : i_tdo;
      o_tck = 1'b0;
   endtask : step
endmodule : test_port_tester
